// ===== pmu_pkg.sv
// Constants and types shared by the mode sequencer
package pmu_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam int REG_NUM = 13;
  localparam logic [3:0] IDX_GENERAL = 4'h0;
  localparam logic [3:0] IDX_LDO1 = 4'h1;
  localparam logic [3:0] IDX_BUCK1 = 4'h6;
  localparam logic [3:0] IDX_BUCK2 = 4'h7;
  localparam logic [3:0] IDX_ENABLE = 4'h8;
  localparam logic [3:0] IDX_PULLDOWN = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'hA;
  localparam logic [3:0] IDX_INT = 4'hB;
  localparam logic [3:0] IDX_MASK = 4'hC;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int GEN_EXT_DVS = 2;
  localparam int GEN_EXT_SLEEP = 1;
  localparam int EN_DVS_V1 = 7;
  localparam int EN_SLEEP = 6;
  localparam int SLOT_LSB = 5;
  localparam int VOLT_MSB = 4;
  localparam int PWM_BIT = 5;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [2:0] SLOT_LAST = 3'h6;
  localparam int CHAN_NUM = 6;

  // ------------------------------------------------------------
  // Setup-select pad codes
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_FLOAT = 2'h2;

  // ------------------------------------------------------------
  // Power-on defaults per setup, index 12 first
  // ------------------------------------------------------------
  localparam logic [12:0][7:0] DEF_SETUP1 = {8'h03, 8'h00, 8'h00, 8'h3F,
    8'h8F, 8'h05, 8'hE5, 8'hFF, 8'h63, 8'h6C, 8'h75, 8'h7D, 8'h01};
  localparam logic [12:0][7:0] DEF_SETUP2 = {8'h03, 8'h00, 8'h00, 8'h3F,
    8'h84, 8'h09, 8'hEB, 8'hFF, 8'hFA, 8'h75, 8'hFD, 8'hFD, 8'h05};
  localparam logic [12:0][7:0] DEF_SETUP3 = {8'h03, 8'h00, 8'h00, 8'h3F,
    8'h8F, 8'h09, 8'hE9, 8'hFF, 8'h65, 8'h6C, 8'h75, 8'h79, 8'h01};

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int STEP_US = 25;
  localparam int BIAS_US = 150;
  localparam int STEP_CYC = STEP_US * CLK_KHZ / 1000;
  localparam int BIAS_CYC = BIAS_US * CLK_KHZ / 1000;
  localparam logic [1:0] POR_WAIT = 2'h3;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR, ST_LOAD, ST_STANDBY, ST_BIAS, ST_START, ST_IDLE, ST_STOP, ST_STOP_REGS
  } pmu_state_t;

  typedef struct packed {
    logic [2:0] slot;
    logic [4:0] volt;
  } pmu_chan_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [5:0] paddr;
    logic [31:0] pwdata;
  } pmu_apb_req_t;

endpackage : pmu_pkg

// ===== pmu_mode_sequencer.sv
// Mode and power sequencer with APB register file
`timescale 1ns/1ps

// Contract
// (RQ1) After power-on reset, sample setup and address pins, load defaults, enter standby.
// (RQ2) Power-on reset to standby completes well within 500 us.
// (RQ3) Standby keeps all outputs off while registers stay writable.
// (RQ4) Start-up begins on enable rising edge or thermal recovery with enable high.
// (RQ5) Start-up waits the bias delay, then enables outputs at programmed steps.
// (RQ6) The sequencing step is 25 us counted from clock cycles.
// (RQ7) After start-up, idle lets software switch and reconfigure every output.
// (RQ8) Shut-down disables in reverse order on enable fall or thermal shutdown.
// (RQ9) Host should not write registers while a sequence runs.
// (RQ10) Outputs outside the sequence switch off at once on enable falling edge.
// (RQ11) During shut-down pulldown and mask registers return to defaults.
// (RQ12) Later in shut-down registers 0 to 8 return to defaults.
// (RQ13) Sleep is selected by a control bit or the voltage-scale pin.
// (RQ14) Buck setting is selected by a control bit or the voltage-scale pin.
// (RQ15) Unmasked early-warning or shutdown thermal event drives interrupt low.
// (RQ16) Reading the interrupt register releases the interrupt output.
// (RQ17) Setups 1 and 3 start regulators one to four together.
// (RQ18) Setup 2 starts only regulator three.
// (RQ19) Setup 2 buck default follows voltage-scale pin: 1.2V low, 1.3V high.
// (RQ20) Setup pin high, low or floating selects setup 1, 2 or 3.
// (RQ21) Under pin control, scale pin high selects the first buck setting.
// (RQ22) Sequencer is a state machine with standby, start-up, idle, shut-down.
module pmu_mode_sequencer #(
  parameter int BIAS_CYCLES = pmu_pkg::BIAS_CYC,
  parameter int STEP_CYCLES = pmu_pkg::STEP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pmu_pkg::pmu_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_pin,
  input wire logic voltage_scale_pin,
  input wire logic [1:0] setup_select_pin,
  input wire logic [1:0] address_select_pin,
  input wire logic thermal_shutdown,
  input wire logic thermal_early_warning,
  output logic [5:0] chan_en,
  output logic [4:0] buck_code,
  output logic force_pwm,
  output logic sleep_en,
  output logic [5:0] pulldown_en,
  output logic [1:0] address_code,
  output logic irq_n_out,
  output logic irq_n_oe_n
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] def_val(input logic [1:0] setup, input int idx);
    logic [7:0] v;
    v = pmu_pkg::DEF_SETUP1[idx];
    if (setup == pmu_pkg::SEL_LOW) begin
      v = pmu_pkg::DEF_SETUP2[idx];
    end else if (setup == pmu_pkg::SEL_FLOAT) begin
      v = pmu_pkg::DEF_SETUP3[idx];
    end
    return v;
  endfunction : def_val

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic en_d_q;
  logic tsd_d_q;
  logic ew_d_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      en_d_q <= 1'b0;
      tsd_d_q <= 1'b0;
      ew_d_q <= 1'b0;
    end else begin
      sync1_q <= {address_select_pin, setup_select_pin, thermal_early_warning,
                  thermal_shutdown, voltage_scale_pin, enable_pin};
      sync2_q <= sync1_q;
      en_d_q <= sync2_q[0];
      tsd_d_q <= sync2_q[2];
      ew_d_q <= sync2_q[3];
    end
  end

  logic en_s;
  logic vs_s;
  logic tsd_s;
  logic ew_s;
  assign en_s = sync2_q[0];
  assign vs_s = sync2_q[1];
  assign tsd_s = sync2_q[2];
  assign ew_s = sync2_q[3];
  logic en_rise;
  logic en_fall;
  logic tsd_rise;
  logic tsd_fall;
  assign en_rise = en_s & ~en_d_q;
  assign en_fall = ~en_s & en_d_q;
  assign tsd_rise = tsd_s & ~tsd_d_q;
  assign tsd_fall = ~tsd_s & tsd_d_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic [3:0] idx;
  logic mapped;
  logic acc;
  logic wr;
  logic rd_int;
  assign idx = apb_req.paddr[5:2];
  assign mapped = (apb_req.paddr[1:0] == 2'h0) && (idx <= pmu_pkg::IDX_MASK);
  assign acc = apb_req.psel & apb_req.penable & pready;
  assign wr = acc & apb_req.pwrite & mapped;
  assign rd_int = acc & ~apb_req.pwrite & (idx == pmu_pkg::IDX_INT) & mapped;

  // ------------------------------------------------------------
  // Sequencer state machine
  // ------------------------------------------------------------
  pmu_pkg::pmu_state_t state_q;
  logic [1:0] por_cnt_q;
  logic [15:0] cnt_q;
  logic [2:0] step_q;
  logic [1:0] setup_q;
  logic tick;
  assign tick = (cnt_q == 16'(STEP_CYCLES - 1)); // [RQ6]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= pmu_pkg::ST_POR;
      por_cnt_q <= 2'h0;
      cnt_q <= 16'h0000;
      step_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      case (state_q)
        pmu_pkg::ST_POR: begin
          // Wait for pins to pass the synchroniser
          por_cnt_q <= por_cnt_q + 2'h1;
          if (por_cnt_q == pmu_pkg::POR_WAIT) begin
            state_q <= pmu_pkg::ST_LOAD; // [RQ1] [RQ2]
          end
        end
        pmu_pkg::ST_LOAD: begin
          state_q <= pmu_pkg::ST_STANDBY; // [RQ1] [RQ22]
        end
        pmu_pkg::ST_STANDBY: begin
          cnt_q <= 16'h0000;
          if ((en_rise & ~tsd_s) | (tsd_fall & en_s)) begin
            state_q <= pmu_pkg::ST_BIAS; // [RQ4]
          end
        end
        pmu_pkg::ST_BIAS: begin
          if (en_fall | tsd_s) begin
            state_q <= pmu_pkg::ST_STOP;
            step_q <= pmu_pkg::SLOT_LAST;
            cnt_q <= 16'h0000;
          end else if (cnt_q == 16'(BIAS_CYCLES - 1)) begin
            state_q <= pmu_pkg::ST_START; // [RQ5]
            step_q <= 3'h0;
            cnt_q <= 16'h0000;
          end
        end
        pmu_pkg::ST_START: begin
          if (en_fall | tsd_s) begin
            state_q <= pmu_pkg::ST_STOP;
            step_q <= pmu_pkg::SLOT_LAST;
            cnt_q <= 16'h0000;
          end else if (tick) begin
            cnt_q <= 16'h0000;
            step_q <= step_q + 3'h1;
            if (step_q == pmu_pkg::SLOT_LAST) begin
              state_q <= pmu_pkg::ST_IDLE; // [RQ7]
            end
          end
        end
        pmu_pkg::ST_IDLE: begin
          if (en_fall | tsd_s) begin
            state_q <= pmu_pkg::ST_STOP; // [RQ8]
            step_q <= pmu_pkg::SLOT_LAST;
            cnt_q <= 16'h0000;
          end
        end
        pmu_pkg::ST_STOP: begin
          if (tick) begin
            cnt_q <= 16'h0000;
            step_q <= step_q - 3'h1;
            if (step_q == 3'h0) begin
              state_q <= pmu_pkg::ST_STOP_REGS;
            end
          end
        end
        pmu_pkg::ST_STOP_REGS: begin
          if (tick) begin
            state_q <= pmu_pkg::ST_STANDBY;
          end
        end
        default: begin
          state_q <= pmu_pkg::ST_POR;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      setup_q <= pmu_pkg::SEL_HIGH;
      address_code <= 2'h0;
    end else if (state_q == pmu_pkg::ST_POR && por_cnt_q == pmu_pkg::POR_WAIT) begin
      setup_q <= sync2_q[5:4]; // [RQ1] [RQ20]
      address_code <= sync2_q[7:6];
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] regs_q [pmu_pkg::REG_NUM];
  logic stop_done;
  logic regs_done;
  assign stop_done = (state_q == pmu_pkg::ST_STOP) && tick && (step_q == 3'h0);
  assign regs_done = (state_q == pmu_pkg::ST_STOP_REGS) && tick;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < pmu_pkg::REG_NUM; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < pmu_pkg::REG_NUM; i++) begin
        if (state_q == pmu_pkg::ST_LOAD) begin
          regs_q[i] <= def_val(setup_q, i); // [RQ1] [RQ17] [RQ18] [RQ19]
        end else if (stop_done && (i == pmu_pkg::IDX_PULLDOWN || i == pmu_pkg::IDX_MASK)) begin
          regs_q[i] <= def_val(setup_q, i); // [RQ11]
        end else if (regs_done && i <= pmu_pkg::IDX_ENABLE) begin
          regs_q[i] <= def_val(setup_q, i); // [RQ12]
        end else if (wr && idx == 4'(i) && i != pmu_pkg::IDX_STATUS && i != pmu_pkg::IDX_INT) begin
          regs_q[i] <= apb_req.pwdata[7:0]; // [RQ3] [RQ7]
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Output enables
  // ------------------------------------------------------------
  logic [5:0] in_seq;
  logic [5:0] at_step;
  logic [5:0] en_bits;
  pmu_pkg::pmu_chan_t chan [pmu_pkg::CHAN_NUM];
  always_comb begin
    for (int c = 0; c < pmu_pkg::CHAN_NUM; c++) begin
      chan[c] = regs_q[c + 1];
      in_seq[c] = chan[c].slot != pmu_pkg::SLOT_NONE;
      at_step[c] = chan[c].slot == step_q;
    end
  end
  assign en_bits = regs_q[pmu_pkg::IDX_ENABLE][5:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_en <= 6'h00;
    end else begin
      case (state_q)
        pmu_pkg::ST_START: begin
          if (en_fall | tsd_s) begin
            chan_en <= chan_en & in_seq; // [RQ10]
          end else if (tick) begin
            chan_en <= chan_en | (at_step & en_bits); // [RQ5] [RQ17] [RQ18]
          end
        end
        pmu_pkg::ST_IDLE: begin
          if (en_fall | tsd_s) begin
            chan_en <= chan_en & in_seq; // [RQ10]
          end else begin
            chan_en <= en_bits; // [RQ7]
          end
        end
        pmu_pkg::ST_STOP: begin
          if (tick) begin
            chan_en <= chan_en & ~at_step; // [RQ8]
          end
        end
        pmu_pkg::ST_STOP_REGS: begin
          chan_en <= 6'h00;
        end
        default: begin
          chan_en <= 6'h00; // [RQ3]
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Buck setting, sleep, pulldowns
  // ------------------------------------------------------------
  logic use_v1;
  logic sleep_req;
  logic running;
  logic [7:0] gen;
  logic [7:0] enr;
  assign gen = regs_q[pmu_pkg::IDX_GENERAL];
  assign enr = regs_q[pmu_pkg::IDX_ENABLE];
  assign use_v1 = gen[pmu_pkg::GEN_EXT_DVS] ? vs_s : enr[pmu_pkg::EN_DVS_V1]; // [RQ14] [RQ21]
  assign sleep_req = gen[pmu_pkg::GEN_EXT_SLEEP] ? ~vs_s : enr[pmu_pkg::EN_SLEEP]; // [RQ13]
  assign running = (state_q == pmu_pkg::ST_IDLE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buck_code <= 5'h00;
      force_pwm <= 1'b0;
      sleep_en <= 1'b0;
      pulldown_en <= 6'h00;
    end else begin
      buck_code <= use_v1 ? regs_q[pmu_pkg::IDX_BUCK1][pmu_pkg::VOLT_MSB:0]
                          : regs_q[pmu_pkg::IDX_BUCK2][pmu_pkg::VOLT_MSB:0]; // [RQ14] [RQ19]
      force_pwm <= regs_q[pmu_pkg::IDX_BUCK2][pmu_pkg::PWM_BIT];
      sleep_en <= running & sleep_req; // [RQ13]
      pulldown_en <= regs_q[pmu_pkg::IDX_PULLDOWN][5:0];
    end
  end

  // ------------------------------------------------------------
  // Thermal flags and interrupt pin
  // ------------------------------------------------------------
  logic [1:0] int_q;
  logic [1:0] int_set;
  assign int_set = {tsd_rise, ew_s & ~ew_d_q};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_q <= 2'h0;
      irq_n_oe_n <= 1'b1;
      irq_n_out <= 1'b0;
    end else begin
      int_q <= (int_q & ~{2{rd_int}}) | int_set; // [RQ15] [RQ16]
      irq_n_oe_n <= ~|(int_q & ~regs_q[pmu_pkg::IDX_MASK][1:0]); // [RQ15]
      irq_n_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (idx == pmu_pkg::IDX_STATUS) begin
      rd_val = {6'h00, tsd_s, ew_s};
    end else if (idx == pmu_pkg::IDX_INT) begin
      rd_val = {6'h00, int_q};
    end else if (mapped) begin
      rd_val = regs_q[idx];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_req.psel & ~apb_req.penable;
      pslverr <= apb_req.psel & ~apb_req.penable & ~mapped;
      if (apb_req.psel & ~apb_req.penable) begin
        prdata <= {24'h00_0000, mapped ? rd_val : 8'h00};
      end
    end
  end

endmodule : pmu_mode_sequencer

// ===== pmu_mode_sequencer_props.sv
// Port checker for the mode sequencer, bound to its top module
`timescale 1ns/1ps
module pmu_mode_sequencer_props #(
  parameter int BIAS_CYCLES = pmu_pkg::BIAS_CYC,
  parameter int STEP_CYCLES = pmu_pkg::STEP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pmu_pkg::pmu_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enable_pin,
  input wire logic [1:0] address_select_pin,
  input wire logic thermal_shutdown,
  input wire logic thermal_early_warning,
  input wire logic [5:0] chan_en,
  input wire logic sleep_en,
  input wire logic [5:0] pulldown_en,
  input wire logic [1:0] address_code,
  input wire logic irq_n_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [15:0] hi_cnt_q;
  logic [15:0] lo_cnt_q;
  // Cycles since the enable pin went high, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_q <= 16'h0;
    end else if (!enable_pin) begin
      hi_cnt_q <= 16'h0;
    end else if (hi_cnt_q != 16'hFFFF) begin
      hi_cnt_q <= hi_cnt_q + 16'h1;
    end
  end
  // Cycles since the enable pin went low, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lo_cnt_q <= 16'h0;
    end else if (enable_pin) begin
      lo_cnt_q <= 16'h0;
    end else if (lo_cnt_q != 16'hFFFF) begin
      lo_cnt_q <= lo_cnt_q + 16'h1;
    end
  end
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_int_read;
    pready && apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == 6'h2C &&
      !thermal_shutdown && !thermal_early_warning;
  endsequence
  property p_ready_access;
    s_setup |=> pready && apb_req.penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("no ready in access cycle");
  property p_ready_alone;
    pready |-> apb_req.penable && $past(apb_req.psel) && !$past(apb_req.penable);
  endproperty
  a_ready_alone: assert property (p_ready_alone) else $error("ready outside access cycle");
  property p_err;
    s_setup ##0 apb_req.paddr[1:0] == 2'h0 |=> pslverr == (apb_req.paddr[5:2] > 4'hC);
  endproperty
  a_err: assert property (p_err) else $error("slave error does not match the address");
  property p_read_data;
    pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data outside the byte lane");
  property p_addr_capture;
    $rose(nrst) |-> ##8 address_code == address_select_pin;
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address pads not captured");
  property p_por_defaults;
    $rose(nrst) |-> ##8 pulldown_en == pmu_pkg::DEF_SETUP1[pmu_pkg::IDX_PULLDOWN][5:0];
  endproperty
  a_por_defaults: assert property (p_por_defaults) else $error("defaults not loaded after power-on");
  property p_quiet_bias;
    hi_cnt_q != 16'h0 && hi_cnt_q < 16'(BIAS_CYCLES + STEP_CYCLES) |-> chan_en == 6'h00;
  endproperty
  a_quiet_bias: assert property (p_quiet_bias) else $error("output on before bias and first step");
  property p_off_standby;
    lo_cnt_q > 16'(9 * STEP_CYCLES + 8) |-> chan_en == 6'h00 && !sleep_en;
  endproperty
  a_off_standby: assert property (p_off_standby) else $error("output on in standby");
  property p_off_only;
    lo_cnt_q > 16'h4 |-> (chan_en & ~$past(chan_en)) == 6'h00;
  endproperty
  a_off_only: assert property (p_off_only) else $error("output turned on during shut-down");
  property p_irq_cause;
    $fell(irq_n_oe_n) |-> thermal_shutdown || thermal_early_warning;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without thermal event");
  property p_irq_release;
    s_int_read |-> ##[1:3] irq_n_oe_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt not released by read");
  property p_sleep_idle;
    $rose(sleep_en) |-> enable_pin && hi_cnt_q > 16'(BIAS_CYCLES);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep outside idle");
endmodule : pmu_mode_sequencer_props

bind pmu_mode_sequencer pmu_mode_sequencer_props #(.BIAS_CYCLES(BIAS_CYCLES), .STEP_CYCLES(STEP_CYCLES)) i_props (
  .clk(clk), .nrst(nrst), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .enable_pin(enable_pin), .address_select_pin(address_select_pin), .thermal_shutdown(thermal_shutdown),
  .thermal_early_warning(thermal_early_warning), .chan_en(chan_en), .sleep_en(sleep_en), .pulldown_en(pulldown_en),
  .address_code(address_code), .irq_n_oe_n(irq_n_oe_n));

// ===== pmu_host_model.sv
// Host controller model: APB master and enable and scale pin driver
`timescale 1ns/1ps
module pmu_host_model (
  input wire logic clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output pmu_pkg::pmu_apb_req_t apb_req,
  output logic enable_pin,
  output logic voltage_scale_pin
);
  initial begin
    apb_req <= '0;
    enable_pin <= 1'b0;
    voltage_scale_pin <= 1'b1;
  end
  // Waits for the answer as long as it takes; only the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                      output logic err);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h0, wd}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    apb_req <= '0;
  endtask : xfer
  // Callers do not write registers while a sequence runs
  task automatic pins(input logic en, input logic vs);
    @(posedge clk);
    enable_pin <= en;
    voltage_scale_pin <= vs;
  endtask : pins
endmodule : pmu_host_model

// ===== pmu_mode_sequencer_bench.sv
// Self-checking testbench of the mode sequencer
`timescale 1ns/1ps
module pmu_mode_sequencer_bench;
  localparam int BIAS = 20;
  localparam int STEP = 20;
  logic clk;
  logic nrst;
  pmu_pkg::pmu_apb_req_t apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enable_pin;
  logic voltage_scale_pin;
  logic [1:0] setup_select_pin;
  logic [1:0] address_select_pin;
  logic thermal_shutdown;
  logic thermal_early_warning;
  logic [5:0] chan_en;
  logic [4:0] buck_code;
  logic force_pwm;
  logic sleep_en;
  logic [5:0] pulldown_en;
  logic [1:0] address_code;
  logic irq_n_out;
  logic irq_n_oe_n;
  int num_errors = 0;
  int samples_checked = 0;
  pmu_host_model i_host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .apb_req(apb_req),
    .enable_pin(enable_pin), .voltage_scale_pin(voltage_scale_pin));
  pmu_mode_sequencer #(.BIAS_CYCLES(BIAS), .STEP_CYCLES(STEP)) i_dut (.clk(clk), .nrst(nrst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .voltage_scale_pin(voltage_scale_pin), .setup_select_pin(setup_select_pin),
    .address_select_pin(address_select_pin), .thermal_shutdown(thermal_shutdown),
    .thermal_early_warning(thermal_early_warning), .chan_en(chan_en), .buck_code(buck_code),
    .force_pwm(force_pwm), .sleep_en(sleep_en), .pulldown_en(pulldown_en), .address_code(address_code),
    .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic e;
    i_host.xfer(1'b0, idx, 8'h00, d, e);
    check(32'({e, d}), 32'(exp));
  endtask : rd
  task automatic wr(input logic [3:0] idx, input logic [7:0] v);
    logic [7:0] d;
    logic e;
    i_host.xfer(1'b1, idx, v, d, e);
  endtask : wr
  task automatic boot(input logic [1:0] sel);
    nrst <= 1'b0;
    setup_select_pin <= sel;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : boot
  task automatic wait_chan(input logic [5:0] exp, output int n);
    n = 0;
    while (chan_en !== exp && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(32'(chan_en), 32'(exp));
  endtask : wait_chan
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    int n;
    logic [7:0] d;
    logic e;
    address_select_pin <= 2'h2;
    thermal_shutdown <= 1'b0;
    thermal_early_warning <= 1'b0;
    boot(pmu_pkg::SEL_HIGH);
    check(32'({pulldown_en, irq_n_oe_n, irq_n_out, address_code}), 32'h3FA);
    for (int i = 0; i < pmu_pkg::REG_NUM; i++) begin
      rd(4'(i), pmu_pkg::DEF_SETUP1[i]);
    end
    i_host.xfer(1'b0, 4'hD, 8'h00, d, e);
    check(32'({e, d}), 32'h100);
    wr(4'hA, 8'hFF);
    rd(4'hA, 8'h00);
    wr(4'h9, 8'h05);
    wr(4'hC, 8'h00);
    wr(4'h8, 8'h9F);
    check(32'({pulldown_en, chan_en}), 32'h140);
    i_host.pins(1'b1, 1'b1);
    wait_chan(6'h0F, n);
    check(32'(n >= BIAS + 4 * STEP && n <= BIAS + 4 * STEP + 6), 32'h1);
    wait_chan(6'h1F, n);
    wr(4'h8, 8'h3F);
    wr(4'h7, 8'h2A);
    repeat (3) @(posedge clk);
    check(32'({chan_en, buck_code, force_pwm}), 32'({6'h3F, 5'h0A, 1'b1}));
    wr(4'h8, 8'hFF);
    repeat (3) @(posedge clk);
    check(32'({sleep_en, buck_code}), 32'h25);
    wr(4'h0, 8'h06);
    wr(4'h8, 8'h3F);
    for (int v = 0; v < 2; v++) begin
      i_host.pins(1'b1, v[0]);
      repeat (5) @(posedge clk);
      check(32'({sleep_en, buck_code}), v[0] ? 32'h05 : 32'h2A);
    end
    thermal_early_warning <= 1'b1;
    repeat (10) @(posedge clk);
    check(32'(irq_n_oe_n), 32'h0);
    thermal_early_warning <= 1'b0;
    repeat (5) @(posedge clk);
    rd(4'hB, 8'h01);
    repeat (3) @(posedge clk);
    check(32'(irq_n_oe_n), 32'h1);
    i_host.pins(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    check(32'(chan_en), 32'h0F);
    wait_chan(6'h00, n);
    check(32'(n >= 4 * STEP - 5 && n <= 4 * STEP + 1), 32'h1);
    repeat (3 * STEP + 5) @(posedge clk);
    check(32'(pulldown_en), 32'h3F);
    rd(4'hC, 8'h03);
    rd(4'h8, 8'h3F);
    repeat (STEP) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      rd(4'(i), pmu_pkg::DEF_SETUP1[i]);
    end
    i_host.pins(1'b1, 1'b1);
    wait_chan(6'h0F, n);
    thermal_shutdown <= 1'b1;
    wait_chan(6'h00, n);
    check(32'(irq_n_oe_n), 32'h1);
    repeat (5 * STEP) @(posedge clk);
    thermal_shutdown <= 1'b0;
    wait_chan(6'h0F, n);
    i_host.pins(1'b0, 1'b1);
    repeat (9 * STEP + 10) @(posedge clk);
    boot(pmu_pkg::SEL_FLOAT);
    rd(4'h1, 8'h79);
    boot(pmu_pkg::SEL_LOW);
    rd(4'h1, 8'hFD);
    i_host.pins(1'b1, 1'b0);
    wait_chan(6'h04, n);
    check(32'(buck_code), 32'h09);
    i_host.pins(1'b1, 1'b1);
    repeat (5) @(posedge clk);
    check(32'(buck_code), 32'h0B);
    stop_test();
  end
endmodule : pmu_mode_sequencer_bench
